// [cox_exec_map.vh]
`ifndef COX_EXEC_MAP_VH
`define COX_EXEC_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define COX_OFS_CMD 8'h00
`define COX_OFS_ACC 8'h04
`define COX_OFS_STATUS 8'h08
`define COX_OFS_FILE_IDX 8'h0c
`define COX_OFS_FILE_DATA 8'h10
`define COX_OFS_DIR 8'h14
`define COX_OFS_WDOG 8'h18

// ****************************************************************
// Command word fields
// ****************************************************************
`define COX_CMD_OP_LSB 0
`define COX_CMD_OP_MSB 3
`define COX_CMD_FADDR_LSB 4
`define COX_CMD_FADDR_MSB 8
`define COX_CMD_DEST_BIT 9
`define COX_CMD_LIT_LSB 16
`define COX_CMD_LIT_MSB 23

// ****************************************************************
// Operation codes
// ****************************************************************
`define COX_OP_NOP 4'h0
`define COX_OP_HALT 4'h1
`define COX_OP_ROTL 4'h2
`define COX_OP_ROTR 4'h3
`define COX_OP_SUB 4'h4
`define COX_OP_SWAP 4'h5
`define COX_OP_DIRLOAD 4'h6
`define COX_OP_XORLIT 4'h7
`define COX_OP_XORFILE 4'h8

// ****************************************************************
// Status register fields
// ****************************************************************
`define COX_ST_CARRY 0
`define COX_ST_DCARRY 1
`define COX_ST_ZERO 2
`define COX_ST_PDOWN 3
`define COX_ST_TOUT 4
`define COX_ST_PCWAKE 5
`define COX_ST_HALTED 6

// ****************************************************************
// Destinations, ports and reset values
// ****************************************************************
`define COX_DEST_ACC 1'b0
`define COX_DEST_FILE 1'b1
`define COX_DIR_PORT_A 5'h06
`define COX_DIR_PORT_B 5'h07
`define COX_DIR_RESET 8'hff
`define COX_WDOG_CLEAR 8'h00
`define COX_PRESC_CLEAR 8'h00
`define COX_ACC_RESET 8'h00
`define COX_FILE_DEPTH 32

`endif

// [cox_alu.v]
`timescale 1ns/1ps
`include "cox_exec_map.vh"

module cox_alu
(
  // Operation select
  input wire [3:0] op_i,
  // Operands
  input wire [7:0] file_i,
  input wire [7:0] acc_i,
  input wire [7:0] lit_i,
  input wire carry_i,
  input wire dcarry_i,
  input wire zero_i,
  // Result and flags
  output reg [7:0] res_o,
  output reg carry_o,
  output reg dcarry_o,
  output reg zero_o
);

  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  reg [8:0] diff;
  reg [4:0] ndiff;

  always @*
  begin
    diff = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001;
    ndiff = {1'b0, file_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
    res_o = file_i;
    carry_o = carry_i;
    dcarry_o = dcarry_i;
    zero_o = zero_i;
    case (op_i)
      `COX_OP_ROTL:
      begin
        res_o = {file_i[6:0], carry_i};
        carry_o = file_i[7];
      end
      `COX_OP_ROTR:
      begin
        res_o = {carry_i, file_i[7:1]};
        carry_o = file_i[0];
      end
      `COX_OP_SUB:
      begin
        res_o = diff[7:0];
        carry_o = diff[8];
        dcarry_o = ndiff[4];
        zero_o = is_zero(diff[7:0]);
      end
      `COX_OP_SWAP:
      begin
        res_o = {file_i[3:0], file_i[7:4]};
      end
      `COX_OP_XORLIT:
      begin
        res_o = acc_i ^ lit_i;
        zero_o = is_zero(acc_i ^ lit_i);
      end
      `COX_OP_XORFILE:
      begin
        res_o = acc_i ^ file_i;
        zero_o = is_zero(acc_i ^ file_i);
      end
      default:
      begin
        res_o = file_i;
      end
    endcase
  end

endmodule // cox_alu

// [cox_exec.v]
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cox_exec_map.vh"

// Overview of operation
// - Halt clears the watchdog counter and its prescaler to zero.
// - Halt sets the timeout flag to one.
// - Halt clears the powerdown flag and leaves the pin change wake flag alone.
// - Halt stops the oscillator and no command executes until a wake event.
// - Rotate left moves carry into bit 0 and bit 7 into carry, touching only carry.
// - Rotate right moves carry into bit 7 and bit 0 into carry, touching only carry.
// - Destination 0 writes the result to the accumulator, 1 back to the file register.
// - Subtract computes file minus accumulator in two's complement and updates C, DC and Z.
// - Nibble exchange swaps the two halves of the source without touching any flag.
// - Pin direction load copies the accumulator into direction register 6 or 7, flags untouched.
// - Xor literal combines the accumulator bitwise with an 8-bit literal.
// - Xor file combines the accumulator with a file register, writes the destination and updates Z.
module cox_exec
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Wake pin
  input wire pin_wake_i,
  // Core outputs
  output reg [7:0] dir_port_a_o,
  output reg [7:0] dir_port_b_o,
  output reg osc_run_o,
  output reg halted_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HALT = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] acc_q;
  reg [7:0] file_q [0:`COX_FILE_DEPTH-1];
  reg [4:0] file_idx_q;
  reg [31:0] cmd_q;
  reg carry_q;
  reg dcarry_q;
  reg zero_q;
  reg timeout_flag_q;
  reg powerdown_flag_q;
  reg pin_change_wake_flag_q;
  reg [7:0] watchdog_counter_q;
  reg [7:0] presc_q;
  reg wake_s1_q;
  reg wake_s2_q;
  reg wake_s3_q;
  reg wake_stable_q;
  integer i;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack
  wire wr_fire = req & wb_we_i & wb_ack_o;
  wire lane0 = wb_sel_i[0];
  wire lane1 = wb_sel_i[1];
  wire lane2 = wb_sel_i[2];
  wire wr_cmd = wr_fire & (wb_adr_i == `COX_OFS_CMD);
  wire wr_acc = wr_fire & lane0 & (wb_adr_i == `COX_OFS_ACC);
  wire wr_status = wr_fire & lane0 & (wb_adr_i == `COX_OFS_STATUS);
  wire wr_fidx = wr_fire & lane0 & (wb_adr_i == `COX_OFS_FILE_IDX);
  wire wr_fdata = wr_fire & lane0 & (wb_adr_i == `COX_OFS_FILE_DATA);

  // ****************************************************************
  // Command fields
  // ****************************************************************
  // Partial lane writes keep the old bytes of the command word
  wire [31:0] cmd_word = {cmd_q[31:24],
                          lane2 ? wb_dat_i[23:16] : cmd_q[23:16],
                          lane1 ? wb_dat_i[15:8] : cmd_q[15:8],
                          lane0 ? wb_dat_i[7:0] : cmd_q[7:0]};
  wire [3:0] op = cmd_word[`COX_CMD_OP_MSB:`COX_CMD_OP_LSB];
  wire [4:0] faddr = cmd_word[`COX_CMD_FADDR_MSB:`COX_CMD_FADDR_LSB];
  wire dest = cmd_word[`COX_CMD_DEST_BIT];
  wire [7:0] lit = cmd_word[`COX_CMD_LIT_MSB:`COX_CMD_LIT_LSB];
  wire running = (state_q == ST_RUN);
  // Commands written while halted are dropped, not queued
  wire exec = wr_cmd & running;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  wire [7:0] alu_res;
  wire alu_carry;
  wire alu_dcarry;
  wire alu_zero;

  cox_alu u_alu
  (
    .op_i(op),
    .file_i(file_q[faddr]),
    .acc_i(acc_q),
    .lit_i(lit),
    .carry_i(carry_q),
    .dcarry_i(dcarry_q),
    .zero_i(zero_q),
    .res_o(alu_res),
    .carry_o(alu_carry),
    .dcarry_o(alu_dcarry),
    .zero_o(alu_zero)
  );

  wire op_is_file = (op == `COX_OP_ROTL) | (op == `COX_OP_ROTR) | (op == `COX_OP_SUB) |
                    (op == `COX_OP_SWAP) | (op == `COX_OP_XORFILE);
  wire res_to_file = exec & op_is_file & (dest == `COX_DEST_FILE);
  wire res_to_acc = exec & ((op_is_file & (dest == `COX_DEST_ACC)) | (op == `COX_OP_XORLIT));
  wire do_halt = exec & (op == `COX_OP_HALT);
  wire flag_op = exec & op_is_file | exec & (op == `COX_OP_XORLIT);

  // ****************************************************************
  // Wake pin synchroniser
  // ****************************************************************
  wire wake_agree = (wake_s2_q == wake_s3_q);
  wire wake_change = wake_agree & (wake_s3_q != wake_stable_q);
  wire wake_evt = wake_change & ~running;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
      wake_s3_q <= 1'b0;
      wake_stable_q <= 1'b0;
    end
    else
    begin
      wake_s1_q <= pin_wake_i;
      wake_s2_q <= wake_s1_q;
      wake_s3_q <= wake_s2_q;
      if (wake_agree)
      begin
        wake_stable_q <= wake_s3_q;
      end
    end
  end

  // ****************************************************************
  // Run and halt
  // ****************************************************************
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:
        if (do_halt)
          state_d = ST_HALT;
      ST_HALT:
        if (wake_evt)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_RUN;
      osc_run_o <= 1'b1;
      halted_o <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      osc_run_o <= (state_d == ST_RUN);
      halted_o <= (state_d == ST_HALT);
    end
  end

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // Counts only while the oscillator runs; a wrap is a timeout
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      watchdog_counter_q <= `COX_WDOG_CLEAR;
      presc_q <= `COX_PRESC_CLEAR;
    end
    else if (do_halt)
    begin
      watchdog_counter_q <= `COX_WDOG_CLEAR;
      presc_q <= `COX_PRESC_CLEAR;
    end
    else if (running)
    begin
      presc_q <= presc_q + 8'h01;
      if (presc_q == 8'hff)
      begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  wire wdog_wrap = running & (presc_q == 8'hff) & (watchdog_counter_q == 8'hff);

  // ****************************************************************
  // Flags
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      carry_q <= 1'b0;
      dcarry_q <= 1'b0;
      zero_q <= 1'b0;
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b1;
      pin_change_wake_flag_q <= 1'b0;
    end
    else
    begin
      if (flag_op)
      begin
        carry_q <= alu_carry;
        dcarry_q <= alu_dcarry;
        zero_q <= alu_zero;
      end
      else if (wr_status)
      begin
        carry_q <= wb_dat_i[`COX_ST_CARRY];
        dcarry_q <= wb_dat_i[`COX_ST_DCARRY];
        zero_q <= wb_dat_i[`COX_ST_ZERO];
      end
      if (do_halt)
      begin
        timeout_flag_q <= 1'b1;
        powerdown_flag_q <= 1'b0;
      end
      else if (wdog_wrap)
        timeout_flag_q <= 1'b0;
      // Set wins over a write-one-to-clear in the same cycle
      if (wake_evt)
        pin_change_wake_flag_q <= 1'b1;
      else if (wr_status & wb_dat_i[`COX_ST_PCWAKE])
        pin_change_wake_flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Accumulator, file registers, directions
  // ****************************************************************
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q <= `COX_ACC_RESET;
      file_idx_q <= 5'h00;
      cmd_q <= 32'h0000_0000;
      dir_port_a_o <= `COX_DIR_RESET;
      dir_port_b_o <= `COX_DIR_RESET;
      for (i = 0; i < `COX_FILE_DEPTH; i = i + 1)
        file_q[i] <= 8'h00;
    end
    else
    begin
      if (wr_cmd)
        cmd_q <= cmd_word;
      if (res_to_acc)
        acc_q <= alu_res;
      else if (wr_acc)
        acc_q <= wb_dat_i[7:0];
      if (res_to_file)
        file_q[faddr] <= alu_res;
      else if (wr_fdata)
        file_q[file_idx_q] <= wb_dat_i[7:0];
      if (wr_fidx)
        file_idx_q <= wb_dat_i[4:0];
      if (exec & (op == `COX_OP_DIRLOAD) & (faddr == `COX_DIR_PORT_A))
        dir_port_a_o <= acc_q;
      if (exec & (op == `COX_OP_DIRLOAD) & (faddr == `COX_DIR_PORT_B))
        dir_port_b_o <= acc_q;
    end
  end

  // ****************************************************************
  // Read mux and acknowledge
  // ****************************************************************
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      `COX_OFS_CMD: rd_d = cmd_q;
      `COX_OFS_ACC: rd_d = {24'h000000, acc_q};
      `COX_OFS_STATUS: rd_d = {25'h0000000, ~running, pin_change_wake_flag_q, timeout_flag_q,
                               powerdown_flag_q, zero_q, dcarry_q, carry_q};
      `COX_OFS_FILE_IDX: rd_d = {27'h0000000, file_idx_q};
      `COX_OFS_FILE_DATA: rd_d = {24'h000000, file_q[file_idx_q]};
      `COX_OFS_DIR: rd_d = {16'h0000, dir_port_b_o, dir_port_a_o};
      `COX_OFS_WDOG: rd_d = {16'h0000, presc_q, watchdog_counter_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Unmapped addresses still ack, reading zero and ignoring writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= (req & ~wb_ack_o) ? rd_d : 32'h0000_0000;
    end
  end

endmodule // cox_exec

// [cox_exec_props.sv]
`timescale 1ns/1ps
`include "cox_exec_map.vh"
module cox_exec_props
(
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Core
  input wire pin_wake_i,
  input wire [7:0] dir_port_a_o,
  input wire [7:0] dir_port_b_o,
  input wire osc_run_o,
  input wire halted_o
);
  // ****************
  // Bus and core checks
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire cmd_wr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == `COX_OFS_CMD;
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
    else $error("ack without request");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_run_halt_excl: assert property (osc_run_o != halted_o)
    else $error("run and halt disagree");
  a_dir_by_cmd: assert property ($changed(dir_port_a_o) || $changed(dir_port_b_o) |-> $past(cmd_wr))
    else $error("direction changed without command");
  a_halt_enter: assert property (osc_run_o && cmd_wr && wb_dat_i[3:0] == `COX_OP_HALT
    |=> halted_o && !osc_run_o)
    else $error("halt not entered");
  a_halt_dir_hold: assert property (halted_o |=> $stable(dir_port_a_o) && $stable(dir_port_b_o))
    else $error("direction changed while halted");
  a_wake_bound: assert property (halted_o && $changed(pin_wake_i) |-> ##[1:12] !halted_o)
    else $error("no wake after pin change");
endmodule // cox_exec_props

bind cox_exec cox_exec_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pin_wake_i(pin_wake_i), .dir_port_a_o(dir_port_a_o), .dir_port_b_o(dir_port_b_o), .osc_run_o(osc_run_o),
  .halted_o(halted_o));

// [cox_exec_tb.sv]
`timescale 1ns/1ps
`include "cox_exec_map.vh"
module cox_exec_tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hf;
  reg [3:0] sel_v = 4'hf;
  reg [31:0] wb_dat_i = 32'h0;
  reg pin_wake_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire [7:0] dir_port_a_o;
  wire [7:0] dir_port_b_o;
  wire osc_run_o;
  wire halted_o;
  integer failures = 0;
  integer cmp_count = 0;
  integer acc, c, dc, z, pd, pcw, dira, dirb, i, op, fa, d, lit, fv, res;
  integer mem [0:31];
  reg [31:0] rnd = 32'h0001_2bee;
  reg [31:0] rd;

  always #2 clk_i = ~clk_i;

  cox_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pin_wake_i(pin_wake_i), .dir_port_a_o(dir_port_a_o), .dir_port_b_o(dir_port_b_o),
    .osc_run_o(osc_run_o), .halted_o(halted_o));

  // ****************
  // Helpers
  // ****************
  function [31:0] lfsr(input [31:0] x);
    integer k;
    begin
      lfsr = x;
      for (k = 0; k < 8; k = k + 1)
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    end
  endfunction

  function integer stv(input integer h);
    stv = h * 64 + pcw * 32 + 16 + pd * 8 + z * 4 + dc * 2 + c;
  endfunction

  task tally_and_finish;
    begin
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // Holds the request until ack is sampled, then releases
  task wb(input we, input [7:0] adr, input [31:0] dat);
    integer n;
    begin
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel_v;
      wb_dat_i <= dat;
      @(posedge clk_i);
      // Only the watchdog ends a wait for ack
      while (wb_ack_o !== 1'b1)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      chk("ack_wait", n, 1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
    end
  endtask

  task rdchk(input [7:0] adr, input string nm, input [31:0] exp);
    begin
      wb(1'b0, adr, 32'h0);
      chk(nm, rd, exp);
    end
  endtask

  // ****************
  // Sequence
  // ****************
  initial
  begin
    for (i = 0; i < 32; i = i + 1)
      mem[i] = 0;
    acc = 0; c = 0; dc = 0; z = 0; pd = 1; pcw = 0; dira = 255; dirb = 255;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(`COX_OFS_STATUS, "status", stv(0));
    rdchk(`COX_OFS_DIR, "dir", 32'hffff);
    wb(1'b1, 8'h1c, 32'h5a);
    rdchk(8'h1c, "unmapped", 0);
    for (i = 0; i < 60; i = i + 1)
    begin
      op = i % 6 < 4 ? i % 6 + 2 : i % 6 + 3;
      rnd = lfsr(rnd);
      fa = rnd[4:0];
      d = rnd[9];
      lit = rnd[23:16];
      fv = rnd[15:8];
      acc = i % 7 == 0 ? fv : rnd[31:24];
      z = rnd[12];
      dc = rnd[11];
      c = rnd[10];
      mem[fa] = fv;
      wb(1'b1, `COX_OFS_FILE_IDX, fa);
      wb(1'b1, `COX_OFS_FILE_DATA, fv);
      wb(1'b1, `COX_OFS_ACC, acc);
      wb(1'b1, `COX_OFS_STATUS, rnd[12:10]);
      wb(1'b1, `COX_OFS_CMD, op | fa << 4 | d << 9 | lit << 16);
      res = op == 2 ? ((fv << 1) | c) & 255 : op == 3 ? (fv >> 1) | (c << 7) : op == 4 ? (fv - acc) & 255
        : op == 5 ? ((fv << 4) | (fv >> 4)) & 255 : op == 7 ? acc ^ lit : acc ^ fv;
      if (op == 2 || op == 3)
        c = op == 2 ? fv >> 7 : fv & 1;
      if (op == 4)
      begin
        c = fv >= acc;
        dc = (fv & 15) >= (acc & 15);
      end
      if (op >= 7 || op == 4)
        z = res == 0;
      if (op == 7 || d == 0)
        acc = res;
      else
        mem[fa] = res;
      rdchk(`COX_OFS_ACC, "acc", acc);
      rdchk(`COX_OFS_FILE_DATA, "file", mem[fa]);
      rdchk(`COX_OFS_STATUS, "status", stv(0));
    end
    for (i = 5; i < 8; i = i + 1)
    begin
      rnd = lfsr(rnd);
      acc = rnd[7:0];
      wb(1'b1, `COX_OFS_ACC, acc);
      wb(1'b1, `COX_OFS_CMD, 6 | i << 4);
      dira = i == 6 ? acc : dira;
      dirb = i == 7 ? acc : dirb;
      rdchk(`COX_OFS_DIR, "dir", dirb << 8 | dira);
      chk("dir_a", dir_port_a_o, dira);
      chk("dir_b", dir_port_b_o, dirb);
      rdchk(`COX_OFS_STATUS, "status", stv(0));
    end
    // Accumulator write without lane 0 is dropped
    sel_v = 4'he;
    wb(1'b1, `COX_OFS_ACC, 32'h77);
    sel_v = 4'hf;
    rdchk(`COX_OFS_ACC, "acc_lane", acc);
    // Halt, then show commands are ignored until the pin wakes us
    wb(1'b1, `COX_OFS_CMD, 1);
    pd = 0;
    @(posedge clk_i);
    chk("halted", halted_o, 1);
    chk("osc", osc_run_o, 0);
    rdchk(`COX_OFS_WDOG, "wdog", 0);
    rdchk(`COX_OFS_STATUS, "status", stv(1));
    wb(1'b1, `COX_OFS_CMD, 7 | 8'h3c << 16);
    rdchk(`COX_OFS_ACC, "acc", acc);
    pin_wake_i <= 1'b1;
    for (i = 0; i < 30 && halted_o !== 1'b0; i = i + 1)
      @(posedge clk_i);
    chk("halted", halted_o, 0);
    chk("osc", osc_run_o, 1);
    pcw = 1;
    rdchk(`COX_OFS_STATUS, "status", stv(0));
    wb(1'b1, `COX_OFS_STATUS, 32'h20 | z << 2 | dc << 1 | c);
    pcw = 0;
    rdchk(`COX_OFS_STATUS, "status", stv(0));
    tally_and_finish;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    failures = failures + 1;
    tally_and_finish;
  end
endmodule // cox_exec_tb
